/* logic/wwd_defs.svh */
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define WWD_IDX_CTRLH   5'h00
`define WWD_IDX_CTRLL   5'h02
`define WWD_IDX_TOH     5'h04
`define WWD_IDX_TOL     5'h06
`define WWD_IDX_WINH    5'h08
`define WWD_IDX_WINL    5'h0a
`define WWD_IDX_REFRESH 5'h0c
`define WWD_IDX_UNLOCK  5'h0e
`define WWD_IDX_CNTH    5'h10
`define WWD_IDX_CNTL    5'h12
`define WWD_IDX_BITES   5'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WWD_BIT_LOCK    14
`define WWD_BIT_TESTON  10
`define WWD_BIT_INTFLAG 15

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WWD_RST_CTRLH   16'h00d3
`define WWD_RST_TO      32'h004c4b40
`define WWD_RST_WIN     32'h00000010
`define WWD_RST_REFRESH 16'hb480
`define WWD_RST_UNLOCK  16'hd928

// ----------------------------------------------------------------
// keys and timing
// ----------------------------------------------------------------
`define WWD_REFRESH_KEY1 16'ha602
`define WWD_REFRESH_KEY2 16'hb480
`define WWD_UNLOCK_KEY1  16'hc520
`define WWD_UNLOCK_KEY2  16'hd928
`define WWD_KEY_GAP      5'd20
`define WWD_WCT_CYCLES   9'd256

`endif

/* logic/wwd_pkg.sv */
package wwd_pkg;

  typedef enum logic [0:0] {
    wwdKeyIdle  = 1'b0,
    wwdKeyArmed = 1'b1
  } wwd_key_t;

  typedef struct packed {
    logic       testLockout;
    logic [1:0] byteChoice;
    logic       testKind;
    logic       waitEn;
    logic       stopEn;
    logic       dbgEn;
    logic       updPerm;
    logic       winOn;
    logic       irqRstEn;
    logic       clkChoice;
    logic       wdOn;
  } wwd_ctrl_t;

  typedef struct packed {
    logic cpuWait;
    logic cpuStop;
    logic cpuDebug;
  } wwd_mode_t;

endpackage

/* logic/wwd_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wwd_defs.svh"
// How it works
// - reserved bits read zero, writes to them do nothing
// - test lockout bit 14 is sticky until reset and blocks functional test
// - byte choice 13:12 picks timer byte 0..3 for the byte test
// - bit 11 picks quick or byte test, only while functional test is on
// - bit 10 runs timer from fast test clock, survives watchdog reset
// - bits 7,6,5 keep timer running in wait, stop, debug
// - update permission bit 4 lets unlock reopen write-once registers
// - bit 3 turns windowed refresh on
// - bit 2 makes exceptions interrupt first, reset one window later
// - bit 1 picks low power oscillator or alternate timer clock
// - watchdog off holds timer at zero, other exceptions still act
// - interrupt flag sets on exception if bit 2, write one clears
// - timeout is a 32-bit timer clock count in two halves
// - windowed refresh below window value is an exception
// - refresh is two keys within 20 cycles, anything else is exception while config window is closed and no unlock is armed
// - unlock is two keys within 20 cycles, opens config window
// - two read-only registers show the timer count halves
// - readback freezes during stop and follows again after exit
// - bite tally counts watchdog resets, power-on clears, write one clears
// - after unlock a config register must be written within window

module wwd_watchdog
  import wwd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        porRst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lpoClk,
  input  wire logic        altClk,
  input  wire logic        fastClk,
  input  wire wwd_mode_t   cpuMode,
  output logic             wdogIrq,
  output logic             wdogReset
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic regHit(input logic [7:0] a, input logic [4:0] i);
    return (a[1:0] == 2'h0) && !a[7] && (a[6:2] == i);
  endfunction

  function automatic wwd_ctrl_t toCtrl(input logic [15:0] d);
    return {d[14:11], d[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wwd_ctrl_t   ctrlReg;
  logic        testOnReg;
  logic        biteSeenReg;
  logic [31:0] toReg;
  logic [31:0] winReg;
  logic [15:0] refreshShowReg;
  logic [15:0] unlockShowReg;
  logic [31:0] timerReg;
  logic [31:0] readbackReg;
  logic [15:0] biteReg;
  logic        intFlagReg;
  logic        pendReg;
  logic [8:0]  pendCntReg;
  logic        cfgOpenReg;
  logic [8:0]  wctCntReg;
  logic        needWriteReg;
  logic [2:0]  clkSync1Reg;
  logic [2:0]  clkSync2Reg;
  logic [2:0]  clkSync3Reg;
  wwd_key_t    keyStateReg [2];
  logic [4:0]  keyGapReg [2];
  logic        keyHit [2];
  logic        keyDone [2];
  logic        keyBad [2];
  logic [15:0] wd;
  logic        accSetup;
  logic        wrAcc;
  logic        mapped;
  logic        wrCtrlH;
  logic        wrCfg;
  logic [15:0] rdData;
  logic [2:0]  clkRise;
  logic        tick;
  logic        run;
  logic        byteTest;
  logic        timeout;
  logic        early;
  logic        refreshOk;
  logic        wctLast;
  logic        missed;
  logic        excAny;
  wire  [31:0] byteNext;
  wire  [3:0]  byteHit;

  localparam logic [4:0] GapLast = 5'(`WWD_KEY_GAP - 5'd1);
  localparam logic [8:0] WctLast = 9'(`WWD_WCT_CYCLES - 9'd1);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign wd       = pwdata[15:0];
  assign accSetup = psel && penable && !pready;
  assign wrAcc    = psel && penable && pready && pwrite && mapped;
  assign mapped   = (paddr[1:0] == 2'h0) && !paddr[7] && !paddr[2]
                    && (paddr[6:2] <= `WWD_IDX_BITES);
  assign wrCtrlH  = wrAcc && cfgOpenReg && regHit(paddr, `WWD_IDX_CTRLH);
  assign wrCfg    = wrAcc && cfgOpenReg && (paddr[6:2] <= `WWD_IDX_WINL);

  always_comb begin
    case (paddr[6:2])
      `WWD_IDX_CTRLH:   rdData = {1'b0, ctrlReg.testLockout, ctrlReg.byteChoice,
                                  ctrlReg.testKind, testOnReg, 2'b00,
                                  ctrlReg[7:0]};
      `WWD_IDX_CTRLL:   rdData = {intFlagReg, 15'h0000};
      `WWD_IDX_TOH:     rdData = toReg[31:16];
      `WWD_IDX_TOL:     rdData = toReg[15:0];
      `WWD_IDX_WINH:    rdData = winReg[31:16];
      `WWD_IDX_WINL:    rdData = winReg[15:0];
      `WWD_IDX_REFRESH: rdData = refreshShowReg;
      `WWD_IDX_UNLOCK:  rdData = unlockShowReg;
      `WWD_IDX_CNTH:    rdData = readbackReg[31:16];
      `WWD_IDX_CNTL:    rdData = readbackReg[15:0];
      `WWD_IDX_BITES:   rdData = biteReg;
      default:          rdData = 16'h0000;
    endcase
  end

  // one wait state: data and error are captured with pready
  always_ff @(posedge clock) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= accSetup;
      if (accSetup) begin
        prdata  <= mapped ? {16'h0000, rdData} : 32'h00000000;
        pslverr <= !mapped;
      end
    end
  end

  // ----------------------------------------------------------------
  // write-once configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrlReg <= toCtrl(`WWD_RST_CTRLH);
    end else if (wrCtrlH) begin
      ctrlReg             <= toCtrl(wd);
      ctrlReg.testLockout <= ctrlReg.testLockout | wd[`WWD_BIT_LOCK];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      toReg  <= `WWD_RST_TO;
      winReg <= `WWD_RST_WIN;
    end else if (wrCfg) begin
      case (paddr[6:2])
        `WWD_IDX_TOH:  toReg[31:16]  <= wd;
        `WWD_IDX_TOL:  toReg[15:0]   <= wd;
        `WWD_IDX_WINH: winReg[31:16] <= wd;
        `WWD_IDX_WINL: winReg[15:0]  <= wd;
        default: begin
        end
      endcase
    end
  end

  // test mode persists over a watchdog bite, only power-on always clears
  always_ff @(posedge clock) begin
    if (porRst) begin
      testOnReg   <= 1'b0;
      biteSeenReg <= 1'b0;
    end else if (rst) begin
      if (!biteSeenReg) begin
        testOnReg <= 1'b0;
      end
    end else begin
      if (wdogReset) begin
        biteSeenReg <= 1'b1;
      end else if (!cfgOpenReg) begin
        biteSeenReg <= 1'b0;
      end
      if (ctrlReg.testLockout) begin
        testOnReg <= 1'b0;
      end else if (wrCtrlH) begin
        testOnReg <= wd[`WWD_BIT_TESTON] & ~wd[`WWD_BIT_LOCK];
      end
    end
  end

  // ----------------------------------------------------------------
  // key sequences: 0 is refresh, 1 is unlock
  // ----------------------------------------------------------------
  assign keyHit[0] = wrAcc && regHit(paddr, `WWD_IDX_REFRESH) && !cfgOpenReg
                     && (keyStateReg[1] == wwdKeyIdle);
  assign keyHit[1] = wrAcc && regHit(paddr, `WWD_IDX_UNLOCK) && !cfgOpenReg;

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : gKey
      localparam logic [15:0] Key1 = (k == 0) ? `WWD_REFRESH_KEY1 : `WWD_UNLOCK_KEY1;
      localparam logic [15:0] Key2 = (k == 0) ? `WWD_REFRESH_KEY2 : `WWD_UNLOCK_KEY2;

      always_ff @(posedge clock) begin
        if (rst) begin
          keyStateReg[k] <= wwdKeyIdle;
          keyGapReg[k]   <= 5'd0;
        end else begin
          case (keyStateReg[k])
            wwdKeyIdle: begin
              keyGapReg[k] <= 5'd0;
              if (keyHit[k] && wd == Key1) begin
                keyStateReg[k] <= wwdKeyArmed;
              end
            end
            wwdKeyArmed: begin
              keyGapReg[k] <= 5'(keyGapReg[k] + 5'd1);
              if (keyHit[k] || keyGapReg[k] == GapLast) begin
                keyStateReg[k] <= wwdKeyIdle;
              end
            end
            default: keyStateReg[k] <= wwdKeyIdle;
          endcase
        end
      end

      assign keyDone[k] = keyHit[k] && (keyStateReg[k] == wwdKeyArmed) && (wd == Key2);
      assign keyBad[k]  = (keyHit[k] && (keyStateReg[k] == wwdKeyIdle) && (wd != Key1))
                        || (keyHit[k] && (keyStateReg[k] == wwdKeyArmed) && (wd != Key2))
                        || (!keyHit[k] && (keyStateReg[k] == wwdKeyArmed)
                            && (keyGapReg[k] == GapLast));
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      refreshShowReg <= `WWD_RST_REFRESH;
      unlockShowReg  <= `WWD_RST_UNLOCK;
    end else if (wrAcc) begin
      if (regHit(paddr, `WWD_IDX_REFRESH)) begin
        refreshShowReg <= wd;
      end
      if (regHit(paddr, `WWD_IDX_UNLOCK)) begin
        unlockShowReg <= wd;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration window
  // ----------------------------------------------------------------
  assign wctLast = cfgOpenReg && (wctCntReg == WctLast);
  assign missed  = wctLast && needWriteReg && !wrCfg;

  always_ff @(posedge clock) begin
    if (rst) begin
      cfgOpenReg   <= 1'b1;
      wctCntReg    <= 9'd0;
      needWriteReg <= 1'b0;
    end else if (cfgOpenReg) begin
      wctCntReg <= 9'(wctCntReg + 9'd1);
      if (wrCfg) begin
        needWriteReg <= 1'b0;
      end
      if (wctLast) begin
        cfgOpenReg   <= 1'b0;
        needWriteReg <= 1'b0;
      end
    end else if (keyDone[1] && ctrlReg.updPerm) begin
      cfgOpenReg   <= 1'b1;
      wctCntReg    <= 9'd0;
      needWriteReg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // timer clock sources
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      clkSync1Reg <= 3'h0;
      clkSync2Reg <= 3'h0;
      clkSync3Reg <= 3'h0;
    end else begin
      clkSync1Reg <= {fastClk, altClk, lpoClk};
      clkSync2Reg <= clkSync1Reg;
      clkSync3Reg <= clkSync2Reg;
    end
  end

  assign clkRise = clkSync2Reg & ~clkSync3Reg;
  assign tick    = testOnReg ? clkRise[2]
                 : (ctrlReg.clkChoice ? clkRise[1] : clkRise[0]);
  assign run     = tick
                 && !(cpuMode.cpuWait  && !ctrlReg.waitEn)
                 && !(cpuMode.cpuStop  && !ctrlReg.stopEn)
                 && !(cpuMode.cpuDebug && !ctrlReg.dbgEn);

  // ----------------------------------------------------------------
  // timer
  // ----------------------------------------------------------------
  assign byteTest = testOnReg && ctrlReg.testKind;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : gByte
      // only the chosen stage counts, the others sit at all ones
      assign byteNext[8*b +: 8] = (ctrlReg.byteChoice == 2'(b))
                                  ? 8'(timerReg[8*b +: 8] + 8'h01)
                                  : 8'hff;
      assign byteHit[b] = (timerReg[8*b +: 8] == toReg[8*b +: 8]);
    end
  endgenerate

  assign timeout   = byteTest ? byteHit[ctrlReg.byteChoice]
                   : (timerReg >= toReg);
  assign early     = keyDone[0] && ctrlReg.winOn && (timerReg < winReg);
  assign refreshOk = keyDone[0] && !early;

  always_ff @(posedge clock) begin
    if (rst || !ctrlReg.wdOn) begin
      timerReg <= 32'h00000000;
    end else if (refreshOk) begin
      timerReg <= 32'h00000000;
    end else if (run) begin
      if (timeout) begin
        timerReg <= 32'h00000000;
      end else begin
        timerReg <= byteTest ? byteNext : 32'(timerReg + 32'h00000001);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readbackReg <= 32'h00000000;
    end else if (!cpuMode.cpuStop) begin
      readbackReg <= timerReg;
    end
  end

  // ----------------------------------------------------------------
  // exceptions, interrupt and bite
  // ----------------------------------------------------------------
  assign excAny = (ctrlReg.wdOn && run && timeout)
                || keyBad[0] || keyBad[1] || early || missed;

  always_ff @(posedge clock) begin
    if (rst) begin
      intFlagReg <= 1'b0;
      pendReg    <= 1'b0;
      pendCntReg <= 9'd0;
      wdogReset  <= 1'b0;
    end else begin
      wdogReset <= 1'b0;
      if (wrAcc && regHit(paddr, `WWD_IDX_CTRLL) && wd[`WWD_BIT_INTFLAG]) begin
        intFlagReg <= 1'b0;
      end
      if (excAny && !pendReg && ctrlReg.irqRstEn) begin
        intFlagReg <= 1'b1;
        pendReg    <= 1'b1;
        pendCntReg <= 9'd0;
      end else if (excAny && !pendReg) begin
        wdogReset <= 1'b1;
      end else if (pendReg) begin
        pendCntReg <= 9'(pendCntReg + 9'd1);
        if (pendCntReg == WctLast) begin
          pendReg   <= 1'b0;
          wdogReset <= 1'b1;
        end
      end
    end
  end

  assign wdogIrq = intFlagReg;

  always_ff @(posedge clock) begin
    if (porRst) begin
      biteReg <= 16'h0000;
    end else if (wrAcc && regHit(paddr, `WWD_IDX_BITES)) begin
      biteReg <= 16'((biteReg & ~wd) + {15'h0000, wdogReset});
    end else if (wdogReset) begin
      biteReg <= 16'(biteReg + 16'h0001);
    end
  end

endmodule

`default_nettype wire

/* bench/wwd_watchdog_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wwd_defs.svh"
module wwd_watchdog_monitor
  import wwd_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        wdogIrq,
  input wire logic        wdogReset
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic [8:0] sinceRst;
  logic       unlockSeen;
  wire logic  wr     = psel & penable & pready & pwrite;
  wire logic  rd     = psel & penable & pready & ~pwrite;
  wire logic  closed = sinceRst > 9'h108;
  wire logic  badRef = wr && paddr == 8'h30 && pwdata[15:0] != `WWD_REFRESH_KEY1 && pwdata[15:0] != `WWD_REFRESH_KEY2;
  wire logic  badUnl = wr && paddr == 8'h38 && pwdata[15:0] != `WWD_UNLOCK_KEY1 && pwdata[15:0] != `WWD_UNLOCK_KEY2;

  always_ff @(posedge clock) begin
    if (rst) begin
      sinceRst <= 9'h000;
    end else if (sinceRst != 9'h1ff) begin
      sinceRst <= sinceRst + 9'h001;
    end
  end

  // unlock writes change how later key writes are judged
  always_ff @(posedge clock) begin
    if (rst) begin
      unlockSeen <= 1'b0;
    end else if (wr && paddr == 8'h38) begin
      unlockSeen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_ctrl_low_rsvd; rd && paddr == 8'h08 |-> prdata[14:0] == 15'h0000; endproperty
  a_ctrl_low_rsvd: assert property (p_ctrl_low_rsvd)
    else $error("ctrl low reserved bits not zero");
  property p_ctrl_high_rsvd; rd && paddr == 8'h00 |-> prdata[15] == 1'b0 && prdata[9:8] == 2'b00; endproperty
  a_ctrl_high_rsvd: assert property (p_ctrl_high_rsvd)
    else $error("ctrl high reserved bits not zero");
  property p_upper_zero; pready |-> prdata[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper half not zero");
  property p_unmapped_zero; pslverr |-> prdata == 32'h00000000; endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");
  property p_irq_clear; $fell(wdogIrq) |-> $past(wr && paddr == 8'h08 && pwdata[15]); endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt flag fell without write one");
  property p_irq_then_reset; $rose(wdogIrq) |-> ##[254:258] wdogReset; endproperty
  a_irq_then_reset: assert property (p_irq_then_reset)
    else $error("reset did not follow interrupt");
  property p_reset_pulse; wdogReset |=> !wdogReset; endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("reset pulse longer than one cycle");
  property p_bad_refresh; badRef && closed && !unlockSeen |=> wdogReset || wdogIrq; endproperty
  a_bad_refresh: assert property (p_bad_refresh)
    else $error("wrong refresh key gave no exception");
  property p_bad_unlock; badUnl && closed && !unlockSeen |=> wdogReset || wdogIrq; endproperty
  a_bad_unlock: assert property (p_bad_unlock)
    else $error("wrong unlock key gave no exception");
endmodule
`default_nettype wire

/* bench/tb_wwd_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wwd_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_wwd_watchdog
  import wwd_pkg::*;
;
  logic        clock, rst, porRst, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, a;
  logic        pready, pslverr, lpoClk, altClk, fastClk, wdogIrq, wdogReset, slvErr;
  wwd_mode_t   cpuMode;
  logic [3:0]  tick = 4'h0;
  logic [15:0] v, toHi;
  int          err_total, cmp_count;
  logic [15:0] expRst [11] = '{16'h00d3, 16'h0000, 16'h004c, 16'h4b40, 16'h0000, 16'h0010,
                               16'hb480, 16'hd928, 16'h0000, 16'h0000, 16'h0000};
  logic [7:0]  badAd [3] = '{8'h04, 8'h58, 8'h84};

  wwd_watchdog wwd_watchdog_i (.clock(clock), .rst(rst), .porRst(porRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lpoClk(lpoClk), .altClk(altClk), .fastClk(fastClk), .cpuMode(cpuMode), .wdogIrq(wdogIrq),
    .wdogReset(wdogReset));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // timer clock pins, each level held at least two bus cycles
  always @(posedge clock) begin
    tick <= tick + 4'h1;
    lpoClk <= tick[2];
    altClk <= tick[3];
    fastClk <= tick[1];
  end

  function automatic logic [15:0] ctrlExp(input logic [15:0] w);
    return w & 16'h7cff;
  endfunction

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [15:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {16'h0000, d};
    penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      $display("mismatch pready expected 1 seen none");
      final_report();
    end
  endtask

  task automatic rdChk(input logic [7:0] ad, input logic [15:0] e);
    apb(1'b0, ad, 16'h0000);
    `CHK($sformatf("reg %h", ad), {16'h0000, e}, q)
  endtask

  // second key lands gap cycles after the first, four at the least
  task automatic key2(input logic [7:0] ad, input logic [15:0] k1, input logic [15:0] k2, input int gap);
    apb(1'b1, ad, k1);
    repeat (gap - 4) @(posedge clock);
    apb(1'b1, ad, k2);
  endtask

  task automatic waitFor(input logic irq, input int lim);
    int n;
    n = 0;
    while ((irq ? wdogIrq : wdogReset) !== 1'b1 && n < lim) begin
      @(posedge clock);
      n++;
    end
    `CHK(irq ? "irq" : "reset", 1'b1, n < lim)
    if (n >= lim) final_report();
  endtask

  task automatic doRst(input logic por, input int n);
    rst <= 1'b1;
    porRst <= por;
    repeat (n) @(posedge clock);
    rst <= 1'b0;
    porRst <= 1'b0;
    @(posedge clock);
  endtask

  initial begin
    {rst, porRst, psel, penable, pwrite} = 5'h18;
    {paddr, pwdata, cpuMode, err_total, cmp_count} = '0;
    void'($urandom(32'h55437954));
    doRst(1'b1, 10);
    for (int i = 0; i < 11; i++) if (i != 8 && i != 9) rdChk(8'(i * 8), expRst[i]);
    foreach (badAd[i]) begin
      apb(1'b0, badAd[i], 16'h0000);
      `CHK("slverr", 1'b1, slvErr)
    end
    cpuMode <= 3'($urandom);
    v = 16'($urandom) & 16'h3cfe;
    apb(1'b1, 8'h00, v | 16'h8300);
    rdChk(8'h00, ctrlExp(v));
    toHi = 16'($urandom);
    apb(1'b1, 8'h10, toHi);
    rdChk(8'h10, toHi);
    v = 16'($urandom);
    apb(1'b1, 8'h28, v);
    rdChk(8'h28, v);
    apb(1'b1, 8'h00, 16'h4400);
    rdChk(8'h00, 16'h4000);
    apb(1'b1, 8'h00, 16'h0410);
    rdChk(8'h00, 16'h4010);
    cpuMode <= '0;
    repeat (300) @(posedge clock);
    apb(1'b1, 8'h10, ~toHi);
    rdChk(8'h10, toHi);
    key2(8'h30, `WWD_REFRESH_KEY1, `WWD_REFRESH_KEY2, 20);
    @(posedge clock);
    `CHK("quiet", 2'b00, {wdogIrq, wdogReset})
    apb(1'b1, 8'h30, 16'($urandom) | 16'h0001);
    waitFor(1'b0, 4);
    doRst(1'b0, 2);
    rdChk(8'h50, 16'h0001);
    rdChk(8'h00, 16'h00d3);
    apb(1'b1, 8'h00, 16'h0014);
    repeat (300) @(posedge clock);
    key2(8'h30, `WWD_REFRESH_KEY1, `WWD_REFRESH_KEY2, 21);
    waitFor(1'b1, 4);
    rdChk(8'h08, 16'h8000);
    apb(1'b1, 8'h08, 16'h8000);
    rdChk(8'h08, 16'h0000);
    waitFor(1'b0, 300);
    doRst(1'b0, 2);
    rdChk(8'h50, 16'h0002);
    apb(1'b1, 8'h50, 16'h0002);
    rdChk(8'h50, 16'h0000);
    apb(1'b1, 8'h00, 16'h0010);
    repeat (300) @(posedge clock);
    key2(8'h38, `WWD_UNLOCK_KEY1, `WWD_UNLOCK_KEY2, 20);
    apb(1'b1, 8'h18, 16'h5555);
    rdChk(8'h18, 16'h5555);
    repeat (300) @(posedge clock);
    key2(8'h38, `WWD_UNLOCK_KEY1, `WWD_UNLOCK_KEY2, 4);
    waitFor(1'b0, 300);
    doRst(1'b0, 2);
    repeat (300) @(posedge clock);
    apb(1'b1, 8'h38, 16'h1111);
    waitFor(1'b0, 4);
    doRst(1'b0, 2);
    apb(1'b1, 8'h00, 16'h0009);
    apb(1'b1, 8'h28, 16'h1000);
    repeat (300) @(posedge clock);
    key2(8'h30, `WWD_REFRESH_KEY1, `WWD_REFRESH_KEY2, 4);
    waitFor(1'b0, 4);
    doRst(1'b0, 2);
    apb(1'b1, 8'h00, 16'h0041);
    repeat (100) @(posedge clock);
    cpuMode.cpuStop <= 1'b1;
    repeat (20) @(posedge clock);
    apb(1'b0, 8'h48, 16'h0000);
    a = q;
    repeat (60) @(posedge clock);
    rdChk(8'h48, a[15:0]);
    cpuMode.cpuStop <= 1'b0;
    repeat (40) @(posedge clock);
    apb(1'b0, 8'h48, 16'h0000);
    `CHK("count", 1'b1, q[15:0] > a[15:0])
    doRst(1'b0, 2);
    apb(1'b1, 8'h10, 16'h0000);
    apb(1'b1, 8'h18, 16'h0008);
    apb(1'b1, 8'h00, 16'h0001);
    waitFor(1'b0, 400);
    doRst(1'b0, 2);
    // byte test on byte 1 against time-out byte 1, fast clock
    apb(1'b1, 8'h18, 16'h0300);
    apb(1'b1, 8'h00, 16'h1c01);
    waitFor(1'b0, 60);
    doRst(1'b0, 2);
    rdChk(8'h00, 16'h04d3);
    doRst(1'b1, 2);
    rdChk(8'h50, 16'h0000);
    final_report();
  end
endmodule

bind wwd_watchdog wwd_watchdog_monitor wwd_watchdog_monitor_i (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .wdogIrq(wdogIrq), .wdogReset(wdogReset));
`default_nettype wire
